// *** iol_pkg.sv ***
package iol_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] IOL_OPT_ADDR = 8'hC8;
  localparam logic [7:0] IOL_STAT_ADDR = 8'hCA;
  localparam logic [7:0] IOL_OPT_RESET = 8'h00;
  localparam int IOL_LES_BIT = 6;
  localparam int IOL_ESB_BIT = 5;
  localparam int IOL_GEN_BIT = 4;

  // ==========================================================
  // sources and timing
  localparam int IOL_NSRC = 5;
  localparam int IOL_NMI_SRC = 0;
  localparam int IOL_STAB_CYCLES_DEF = 2048;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    IOL_MODE_NORMAL,
    IOL_MODE_IRQ,
    IOL_MODE_NMI
  } iol_mode_e;

  typedef enum logic [1:0] {
    IOL_RUN,
    IOL_WAIT,
    IOL_STOP,
    IOL_STAB
  } iol_pwr_e;

  typedef struct packed {
    logic level_edge_select;
    logic edge_polarity_select;
    logic gen;
  } iol_opt_s;

  typedef struct packed {
    logic instr_end;
    logic wait_exec;
    logic stop_exec;
    logic ack;
    logic [2:0] ack_src;
    iol_mode_e mode;
  } iol_core_s;

endpackage

// *** iol_top.sv ***
`timescale 1ns/1ps
// Contract
// (R01) option register is write-only; reads give zero, no bit operations
// (R02) option register clears to zero on every reset
// (R03) bits 7 and 3..0 of the option register do nothing
// (R04) bit 6 set makes source 1 level sensitive, clear makes it edge
// (R05) bit 5 picks the edge polarity of source 2
// (R06) bit 4 enables maskable sources; the non-maskable one stays active
// (R07) with bit 4 clear the non-maskable source cannot wake the device
// (R08) timer/osc to 3, converter to 4, serial to 1, pins to 2, supply to 0
// (R09) each peripheral event also passes its own enable bit; the serial event spi_eot has no enable and drives source 1 directly
// (R10) wait halts instructions, clock and peripherals keep running
// (R11) pin or watchdog reset during wait restarts normally
// (R12) wake from wait resumes with no delay
// (R13) stop halts the oscillator until an interrupt or reset
// (R14) wake from stop waits for the oscillator to settle
// (R15) with the watchdog active, stop behaves as wait
// (R16) from main code the interrupt is serviced, then code continues
// (R17) inside the non-maskable routine wake just continues, no service
// (R18) inside a maskable routine a maskable wake just continues
// (R19) inside a maskable routine a non-maskable wake is serviced first
// (R20) wait or stop is ignored while an enabled request is pending
// (R21) servicing and wake never change the oscillator selection
// (R22) source 2 is edge sensitive: rising when bit 5 set, else falling
// (R23) sources 3 and 4 are level sensitive and not latched
// (R24) edge latches clear at service start and hold only the first edge
// (R25) stop wake delay is a fixed counter of cycles set by a parameter
module iol_top
  import iol_pkg::*;
#(
  parameter int NPIN = 20,
  parameter int NTMR = 2,
  parameter int STAB_CYCLES = IOL_STAB_CYCLES_DEF
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output logic [7:0] reg_rdata,
  // peripheral events and their enables
  input wire [NTMR-1:0] timer_zero_flag,
  input wire [NTMR-1:0] timer_irq_enable,
  input wire converter_eoc,
  input wire converter_irq_enable,
  input wire spi_eot,
  input wire supply_monitor_flag,
  input wire supply_monitor_irq_enable,
  input wire lowfreq_osc_event,
  input wire lowfreq_osc_irq_enable,
  // port pins with direction, option and data bits
  input wire [NPIN-1:0] port_pin,
  input wire [NPIN-1:0] port_dir,
  input wire [NPIN-1:0] port_opt,
  input wire [NPIN-1:0] port_data,
  // core and watchdog
  input iol_core_s core_ctl,
  input wire watchdog_active,
  // requests and power control
  output logic irq_take,
  output logic [2:0] irq_take_src,
  output logic [IOL_NSRC-1:0] irq_pend,
  output logic cpu_halt,
  output logic osc_run,
  output logic wake,
  output logic wake_service
);

  // ==========================================================
  // option register and read port
  iol_opt_s opt_ff, nxt_opt;
  logic [7:0] rdata_ff, nxt_rdata;
  iol_pwr_e pwr_ff, nxt_pwr;
  logic [IOL_NSRC-1:0] latch_ff, nxt_latch;

  always_comb begin
    nxt_opt = opt_ff;
    nxt_rdata = 8'h00;
    if (reg_wr && reg_addr == IOL_OPT_ADDR) begin // R03
      // only bits 6..4 are stored; the rest are dropped here
      nxt_opt.level_edge_select = reg_wdata[IOL_LES_BIT]; // R04
      nxt_opt.edge_polarity_select = reg_wdata[IOL_ESB_BIT]; // R05
      nxt_opt.gen = reg_wdata[IOL_GEN_BIT]; // R06
    end
    if (reg_rd && reg_addr == IOL_STAT_ADDR) begin
      nxt_rdata = {1'b0, pwr_ff, latch_ff};
    end
    // option register answers zero on read R01
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opt_ff <= iol_opt_s'(IOL_OPT_RESET[6:4]); // R02
      rdata_ff <= 8'h00;
    end else begin
      opt_ff <= nxt_opt;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // event routing onto source lines
  logic [NPIN-1:0] pin_armed;
  logic src0_evt, src1_evt, src3_lvl, src4_lvl;
  logic src2_line;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      // input with pull-up and interrupt: dir 0, option 1, data 0
      assign pin_armed[gi] = !port_dir[gi] && port_opt[gi] &&
                             !port_data[gi]; // R09
    end
  endgenerate

  always_comb begin
    src0_evt = supply_monitor_flag && supply_monitor_irq_enable; // R08
    src1_evt = spi_eot; // R08
    src3_lvl = |(timer_zero_flag & timer_irq_enable) ||
               (lowfreq_osc_event && lowfreq_osc_irq_enable); // R08 R09
    src4_lvl = converter_eoc && converter_irq_enable; // R08 R09
    // armed pins pull one shared line low
    src2_line = &(port_pin | ~pin_armed); // R08
  end

  // ==========================================================
  // edge detection and request latches
  logic src0_prev_ff, src1_prev_ff, src2_prev_ff;
  logic [IOL_NSRC-1:0] req;
  logic [IOL_NSRC-1:0] set_evt;
  logic [IOL_NSRC-1:0] clr_evt;

  always_comb begin
    set_evt = '0;
    set_evt[0] = src0_evt && !src0_prev_ff;
    set_evt[1] = src1_evt && !src1_prev_ff && !opt_ff.level_edge_select; // R04
    set_evt[2] = opt_ff.edge_polarity_select ? (src2_line && !src2_prev_ff)
                            : (!src2_line && src2_prev_ff); // R22
    clr_evt = '0;
    if (core_ctl.ack && core_ctl.ack_src < 3'(IOL_NSRC)) begin
      clr_evt[core_ctl.ack_src] = 1'b1; // R24
    end
    // an edge in the clearing cycle is kept R24
    nxt_latch = (latch_ff & ~clr_evt) | set_evt; // R24
    nxt_latch[4:3] = 2'b00; // R23
    if (opt_ff.level_edge_select) begin
      nxt_latch[1] = 1'b0; // R04
    end
    req = latch_ff;
    req[1] = opt_ff.level_edge_select ? src1_evt : latch_ff[1]; // R04
    req[3] = src3_lvl; // R23
    req[4] = src4_lvl; // R23
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_ff <= '0;
      src0_prev_ff <= 1'b0;
      src1_prev_ff <= 1'b0;
      src2_prev_ff <= 1'b1;
    end else begin
      latch_ff <= nxt_latch;
      src0_prev_ff <= src0_evt;
      src1_prev_ff <= src1_evt;
      src2_prev_ff <= src2_line;
    end
  end

  // ==========================================================
  // request gating by core mode and global enable
  logic [IOL_NSRC-1:0] enabled_req;
  logic [IOL_NSRC-1:0] allowed_req;
  logic any_enabled;
  logic wake_req;
  logic take_hit;
  logic [2:0] take_src;

  always_comb begin
    enabled_req = req;
    if (!opt_ff.gen) begin
      enabled_req[IOL_NSRC-1:1] = '0; // R06
    end
    any_enabled = |enabled_req;
    // non-maskable still serviced with gen low, but never wakes R07
    wake_req = opt_ff.gen && |req; // R07
    unique case (core_ctl.mode)
      IOL_MODE_NORMAL: allowed_req = enabled_req; // R16
      IOL_MODE_IRQ: allowed_req = {4'b0000, enabled_req[0]}; // R18 R19
      IOL_MODE_NMI: allowed_req = '0; // R17
      default: allowed_req = '0;
    endcase
    take_hit = 1'b0;
    take_src = 3'd0;
    // fixed priority: source 0 highest, source 4 lowest
    for (int i = IOL_NSRC - 1; i >= 0; i--) begin
      if (allowed_req[i]) begin
        take_hit = 1'b1;
        take_src = 3'(i);
      end
    end
  end

  // ==========================================================
  // low-power state machine
  logic [$clog2(STAB_CYCLES+1)-1:0] stab_ff, nxt_stab;
  logic take_ff, nxt_take;
  logic [2:0] take_src_ff, nxt_take_src;
  logic wake_ff, nxt_wake;
  logic wake_svc_ff, nxt_wake_svc;
  logic halt_ff, nxt_halt;
  logic osc_ff, nxt_osc;

  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_stab = stab_ff;
    nxt_wake = 1'b0;
    nxt_wake_svc = 1'b0;
    nxt_take = 1'b0;
    nxt_take_src = take_src_ff;
    unique case (pwr_ff)
      IOL_RUN: begin
        // sample lines only at instruction end R23
        if (core_ctl.instr_end && take_hit) begin
          nxt_take = 1'b1;
          nxt_take_src = take_src;
        end
        if (any_enabled) begin
          nxt_pwr = IOL_RUN; // R20
        end else if (core_ctl.stop_exec && !watchdog_active) begin
          nxt_pwr = IOL_STOP; // R13
        end else if (core_ctl.wait_exec || core_ctl.stop_exec) begin
          nxt_pwr = IOL_WAIT; // R10 R15
        end
      end
      IOL_WAIT: begin
        if (wake_req) begin
          nxt_pwr = IOL_RUN; // R12
          nxt_wake = 1'b1;
          nxt_wake_svc = take_hit; // R16 R17 R18 R19
        end
      end
      IOL_STOP: begin
        if (wake_req) begin
          nxt_pwr = IOL_STAB; // R14
          nxt_stab = ($clog2(STAB_CYCLES+1))'(STAB_CYCLES - 1); // R25
        end
      end
      IOL_STAB: begin
        if (stab_ff == '0) begin
          nxt_pwr = IOL_RUN; // R14
          nxt_wake = 1'b1;
          nxt_wake_svc = take_hit; // R16 R17 R18 R19
        end else begin
          nxt_stab = stab_ff - 1'b1; // R25
        end
      end
    endcase
    nxt_halt = (nxt_pwr != IOL_RUN); // R10
    // only the run/stop gate is driven; selection is left alone R21
    nxt_osc = (nxt_pwr != IOL_STOP); // R13 R21
  end

  always_ff @(posedge sys_clk) begin
    // any reset, pin or watchdog, returns straight to run R11
    if (rst) begin
      pwr_ff <= IOL_RUN; // R11
      stab_ff <= '0;
      take_ff <= 1'b0;
      take_src_ff <= 3'd0;
      wake_ff <= 1'b0;
      wake_svc_ff <= 1'b0;
      halt_ff <= 1'b0;
      osc_ff <= 1'b1;
    end else begin
      pwr_ff <= nxt_pwr;
      stab_ff <= nxt_stab;
      take_ff <= nxt_take;
      take_src_ff <= nxt_take_src;
      wake_ff <= nxt_wake;
      wake_svc_ff <= nxt_wake_svc;
      halt_ff <= nxt_halt;
      osc_ff <= nxt_osc;
    end
  end

  // ==========================================================
  // outputs
  logic [IOL_NSRC-1:0] pend_ff, nxt_pend;

  always_comb begin
    // requests the core may take in its present mode
    nxt_pend = allowed_req; // R16 R17 R18 R19
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq_take = take_ff;
  assign irq_take_src = take_src_ff;
  assign irq_pend = pend_ff;
  assign cpu_halt = halt_ff;
  assign osc_run = osc_ff;
  assign wake = wake_ff;
  assign wake_service = wake_svc_ff;

endmodule // iol_top

// *** iol_core_model.sv ***
`timescale 1ns/1ps
// ==========
// core stand-in: steps, sleeps, acks takes
module iol_core_model
  import iol_pkg::*;
(
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // bench commands
  input wire go_wait,
  input wire go_stop,
  input iol_mode_e mode,
  // block side
  input logic irq_take,
  input logic [2:0] irq_take_src,
  input logic cpu_halt,
  output iol_core_s core_ctl
);
  logic [1:0] step;
  always_ff @(posedge sys_clk) begin
    step <= rst ? 2'h0 : step + 2'h1;
    core_ctl <= '0;
    if (!rst) begin
      core_ctl.instr_end <= step == 2'h3 && !cpu_halt;
      core_ctl.wait_exec <= go_wait;
      core_ctl.stop_exec <= go_stop;
      core_ctl.ack <= irq_take;
      core_ctl.ack_src <= irq_take_src;
      core_ctl.mode <= mode;
    end
  end
endmodule // iol_core_model

// *** iol_top_sva.sv ***
`timescale 1ns/1ps
// ==========
// port checker
module iol_top_sva
  import iol_pkg::*;
#(
  parameter int STAB_CYCLES = IOL_STAB_CYCLES_DEF
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input logic [7:0] reg_rdata,
  // core and power
  input iol_core_s core_ctl,
  input wire watchdog_active,
  input logic irq_take,
  input logic cpu_halt,
  input logic osc_run,
  input logic wake,
  input logic wake_service
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  opt_read_a: assert property (
    reg_rd && reg_addr == IOL_OPT_ADDR |=> reg_rdata == 8'h00)
    else $error("option read not zero");
  stop_halt_a: assert property (
    !osc_run |-> cpu_halt) else $error("osc off while running");
  stop_cause_a: assert property (
    $fell(osc_run) |-> $past(core_ctl.stop_exec) && !$past(watchdog_active))
    else $error("osc stopped without stop");
  // cycles since the oscillator restarted, for the settle delay
  logic stab_on_ff;
  int stab_cnt_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stab_on_ff <= 1'b0;
      stab_cnt_ff <= 0;
    end else if ($rose(osc_run)) begin
      stab_on_ff <= 1'b1;
      stab_cnt_ff <= 1;
    end else if (stab_on_ff) begin
      stab_on_ff <= !wake;
      stab_cnt_ff <= stab_cnt_ff + 1;
    end
  end
  stab_early_a: assert property (
    $rose(osc_run) || (stab_on_ff && stab_cnt_ff < STAB_CYCLES) |-> !wake)
    else $error("wake before settle delay");
  stab_end_a: assert property (
    stab_on_ff && stab_cnt_ff == STAB_CYCLES |-> wake)
    else $error("no wake after settle delay");
  halt_exit_a: assert property (
    $fell(cpu_halt) |-> wake) else $error("halt left without wake");
  wake_halt_a: assert property (
    wake |-> !cpu_halt && $past(cpu_halt)) else $error("wake not from halt");
  service_gate_a: assert property (
    wake_service |-> wake) else $error("service without wake");
  take_cause_a: assert property (
    irq_take |-> $past(core_ctl.instr_end) && !$past(cpu_halt))
    else $error("take without instruction end");
endmodule // iol_top_sva

bind iol_top iol_top_sva #(.STAB_CYCLES(STAB_CYCLES)) u_sva (
  .sys_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .core_ctl,
  .watchdog_active, .irq_take, .cpu_halt, .osc_run, .wake, .wake_service
);

// *** interrupt_option_and_low_power_tb.sv ***
`timescale 1ns/1ps
// ==========
// bench top
module interrupt_option_and_low_power_tb;
  import iol_pkg::*;
  localparam int STAB = 4;
  logic sys_clk = '0;
  logic rst = '1;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
  logic reg_wr = '0, reg_rd = '0, watchdog_active = '0;
  logic [1:0] timer_zero_flag = '0, timer_irq_enable = '0;
  logic converter_eoc = '0, supply_monitor_flag = '0, lowfreq_osc_event = '0;
  logic spi_eot = '0;
  logic [IOL_NSRC-1:0] irq_pend;
  logic [19:0] port_pin = '1, port_opt = 20'h0_0001;
  logic go_wait = '0, go_stop = '0;
  iol_mode_e mode = IOL_MODE_NORMAL;
  iol_core_s core_ctl;
  logic irq_take, cpu_halt, osc_run, wake, wake_service;
  logic [2:0] irq_take_src;
  logic [3:0] ev;
  int n_errors = 0, n_tests = 0;
  assign ev = {osc_run, cpu_halt, wake, irq_take};
  always #25 sys_clk = ~sys_clk;
  iol_top #(.STAB_CYCLES(STAB)) u_dut (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_zero_flag, .timer_irq_enable, .converter_eoc,
    .converter_irq_enable(1'b1), .spi_eot, .supply_monitor_flag,
    .supply_monitor_irq_enable(1'b1), .lowfreq_osc_event,
    .lowfreq_osc_irq_enable(1'b1), .port_pin, .port_dir(20'h0_0000),
    .port_opt, .port_data(20'h0_0000), .core_ctl, .watchdog_active,
    .irq_take, .irq_take_src, .irq_pend, .cpu_halt, .osc_run, .wake,
    .wake_service
  );
  iol_core_model u_core (
    .sys_clk, .rst, .go_wait, .go_stop, .mode, .irq_take, .irq_take_src,
    .cpu_halt, .core_ctl
  );
  // ==========
  // shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic watch(input int b, n, output int k);
    for (k = 0; k < n; k++) begin
      @(posedge sys_clk);
      #1;
      if (ev[b] === 1'b1) break;
    end
  endtask
  task automatic await(input int b, input string what);
    int k;
    watch(b, 40, k);
    if (k == 40) begin
      chk(8'h00, 8'h01, what);
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_wr <= '1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= '0;
  endtask
  task automatic rd(input logic [7:0] a, exp, input string what);
    @(posedge sys_clk);
    reg_rd <= '1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= '0;
    #1;
    chk(reg_rdata, exp, what);
  endtask
  task automatic low_power(input logic stop);
    @(posedge sys_clk);
    go_stop <= stop;
    go_wait <= !stop;
    @(posedge sys_clk);
    go_stop <= '0;
    go_wait <= '0;
    await(2, "halt");
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    int k;
    wr(8'hC8, 8'hFF);
    rd(8'hC8, 8'h00, "option");
    rd(8'h00, 8'h00, "unmapped");
    wr(8'hC8, 8'h8F);
    timer_zero_flag <= 2'h1;
    timer_irq_enable <= 2'h1;
    watch(0, 10, k);
    chk(8'(k), 8'h0A, "unused bits");
    wr(8'hC8, 8'h10);
    await(0, "timer take");
    chk(8'(irq_take_src), 8'h03, "timer src");
    chk(8'(irq_pend), 8'h08, "timer pend");
    @(posedge sys_clk);
    timer_irq_enable <= 2'h0;
    watch(0, 10, k);
    chk(8'(k), 8'h0A, "timer mask");
    @(posedge sys_clk);
    timer_zero_flag <= 2'h0;
    $display("regs done");
  endtask
  task automatic t_nmi();
    wr(8'hC8, 8'h00);
    supply_monitor_flag <= '1;
    await(0, "nmi take");
    chk(8'(irq_take_src), 8'h00, "nmi src");
    repeat (3) @(posedge sys_clk);
    supply_monitor_flag <= '0;
    rd(8'hCA, 8'h00, "latch");
    $display("nmi done");
  endtask
  task automatic t_spi();
    int k;
    wr(8'hC8, 8'h30);
    port_pin <= 20'hF_FFFE;
    watch(0, 8, k);
    chk(8'(k), 8'h08, "pin fall ignored");
    @(posedge sys_clk);
    port_pin <= 20'hF_FFFF;
    await(0, "pin rise take");
    chk(8'(irq_take_src), 8'h02, "pin rise src");
    @(posedge sys_clk);
    spi_eot <= '1;
    await(0, "serial take");
    chk(8'(irq_take_src), 8'h01, "serial src");
    watch(0, 10, k);
    chk(8'(k), 8'h0A, "serial edge once");
    wr(8'hC8, 8'h50);
    await(0, "serial level take");
    chk(8'(irq_take_src), 8'h01, "serial level src");
    @(posedge sys_clk);
    spi_eot <= '0;
    $display("spi done");
  endtask
  task automatic t_wait(input iol_mode_e m, input logic nmi, svc,
                        input logic [7:0] pend);
    wr(8'hC8, 8'h10);
    mode <= m;
    low_power(1'b0);
    rd(8'hCA, 8'h20, "wait state");
    chk(8'(osc_run), 8'h01, "wait osc");
    @(posedge sys_clk);
    if (nmi) supply_monitor_flag <= '1;
    else converter_eoc <= '1;
    await(1, "wait wake");
    chk(8'(wake_service), 8'(svc), "service");
    chk(8'(irq_pend), pend, "wake pend");
    @(posedge sys_clk);
    converter_eoc <= '0;
    supply_monitor_flag <= '0;
    if (nmi) begin
      await(0, "nmi service");
      chk(8'(irq_take_src), 8'h00, "nmi first");
    end
    $display("wait done");
  endtask
  task automatic t_stop();
    int k;
    low_power(1'b1);
    chk(8'(osc_run), 8'h00, "stop osc");
    @(posedge sys_clk);
    port_pin <= 20'hF_FFFE;
    await(3, "osc restart");
    watch(1, 10, k);
    chk(8'(k), 8'(STAB - 1), "stab");
    await(0, "pin take");
    chk(8'(irq_take_src), 8'h02, "pin src");
    @(posedge sys_clk);
    port_pin <= 20'hF_FFFF;
    $display("stop done");
  endtask
  task automatic t_wdog();
    int k;
    @(posedge sys_clk);
    watchdog_active <= '1;
    low_power(1'b1);
    chk(8'(osc_run), 8'h01, "wdog osc");
    @(posedge sys_clk);
    lowfreq_osc_event <= '1;
    await(1, "wdog wake");
    @(posedge sys_clk);
    go_wait <= '1;
    @(posedge sys_clk);
    go_wait <= '0;
    watch(2, 8, k);
    chk(8'(k), 8'h08, "pending wait");
    @(posedge sys_clk);
    lowfreq_osc_event <= '0;
    watchdog_active <= '0;
    $display("wdog done");
  endtask
  task automatic t_gen0();
    int k;
    wr(8'hC8, 8'h00);
    low_power(1'b0);
    @(posedge sys_clk);
    supply_monitor_flag <= '1;
    watch(1, 10, k);
    chk(8'(k), 8'h0A, "gen off wake");
    @(posedge sys_clk);
    supply_monitor_flag <= '0;
    rst <= '1;
    repeat (2) @(posedge sys_clk);
    rst <= '0;
    #1;
    chk(8'(cpu_halt), 8'h00, "reset halt");
    rd(8'hCA, 8'h00, "reset status");
    wr(8'hC8, 8'h70);
    rst <= '1;
    repeat (2) @(posedge sys_clk);
    rst <= '0;
    timer_zero_flag <= 2'h1;
    timer_irq_enable <= 2'h1;
    watch(0, 10, k);
    chk(8'(k), 8'h0A, "reset option");
    @(posedge sys_clk);
    timer_zero_flag <= 2'h0;
    timer_irq_enable <= 2'h0;
    $display("gen0 done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= '0;
    t_regs();
    t_nmi();
    t_spi();
    t_wait(IOL_MODE_NMI, 1'b0, 1'b0, 8'h00);
    t_wait(IOL_MODE_IRQ, 1'b0, 1'b0, 8'h00);
    t_wait(IOL_MODE_IRQ, 1'b1, 1'b1, 8'h01);
    t_wait(IOL_MODE_NORMAL, 1'b0, 1'b1, 8'h10);
    t_stop();
    t_wdog();
    t_gen0();
    complete_run();
  end
endmodule // interrupt_option_and_low_power_tb
